// ==== rtl/stack_page_check.sv ====
// Stack pointer, stack limit and page mapped access checker
`timescale 1ns/100ps
module stack_page_check
    import stack_page_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Stack operations from the core
    input wire logic [2:0] i_stack_op,
    input wire logic [15:0] i_push_data,
    input wire logic [15:0] i_sp_load,
    input wire logic [22:0] i_pc,
    input wire logic [7:0] i_status_low_byte,
    // Stack limit write
    input wire logic i_limit_wr,
    input wire logic [15:0] i_limit_data,
    // Data access, indirect or direct
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [15:0] i_acc_addr,
    input wire logic i_acc_direct,
    // Page registers
    input wire logic [8:0] i_data_read_page_reg,
    input wire logic [8:0] i_data_write_page_reg,
    // Stack memory request
    output logic o_stk_valid,
    output logic o_stk_write,
    output logic [15:0] o_stk_addr,
    output logic [15:0] o_stk_wdata,
    // Data access result
    output logic o_acc_valid,
    output logic o_acc_write,
    output logic [23:0] o_ext_addr,
    output logic o_acc_near,
    // State and traps
    output logic [15:0] o_stack_pointer_reg,
    output logic [15:0] o_stack_limit_reg,
    output logic o_stack_error_trap,
    output logic o_address_error_trap
);
    // Registered state
    logic [15:0] sp_q, sp_d; // Next free word
    logic [15:0] lim_q, lim_d; // No reset on purpose
    logic stk_valid_q, stk_valid_d;
    logic stk_write_q, stk_write_d;
    logic [15:0] stk_addr_q, stk_addr_d;
    logic [15:0] stk_wdata_q, stk_wdata_d;
    logic acc_valid_q, acc_valid_d;
    logic acc_write_q, acc_write_d;
    logic [23:0] ext_q, ext_d; // Mapped extended address
    logic near_q, near_d;
    logic serr_q, serr_d;
    logic aerr_q, aerr_d;
    // Mapper outputs, page select into the mapper and the cast op code
    logic [23:0] map_addr;
    logic map_fault;
    logic map_near;
    logic [8:0] sel_page;
    stack_op_t op;

    // Effective stack address check against limit and underflow
    // Equal to the limit passes, so the word at the limit stays usable
    function automatic logic stack_bad(input logic [15:0] ea, input logic [15:0] lim);
        stack_bad = (ea > lim) || (ea < UNDERFLOW_LIMIT);
    endfunction

    // Op code cast once; unused codes land in the idle branch
    assign op = stack_op_t'(i_stack_op);
    // Page chosen by direction of the access
    assign sel_page = i_acc_write ? i_data_write_page_reg : i_data_read_page_reg;

    page_map u_map (
        .i_addr(i_acc_addr),
        .i_page(sel_page),
        .o_ext_addr(map_addr),
        .o_page_fault(map_fault),
        .o_near(map_near)
    );

    // Stack next state
    always_comb begin
        logic [15:0] ea;
        // Defaults: no request, no trap, pointer held
        ea = sp_q;
        sp_d = sp_q;
        stk_valid_d = 1'b0;
        stk_write_d = 1'b0;
        stk_addr_d = stk_addr_q;
        stk_wdata_d = stk_wdata_q;
        serr_d = 1'b0;
        // One op per cycle, so only one stack address is formed
        case (op)
            OP_PUSH, OP_CALL, OP_EXC: begin
                // Write at current pointer first, then step up
                ea = sp_q;
                if (stack_bad(ea, lim_q)) begin
                    serr_d = 1'b1;
                end else begin
                    stk_valid_d = 1'b1;
                    stk_write_d = 1'b1;
                    stk_addr_d = ea;
                    sp_d = sp_q + WORD_STEP;
                    if (op == OP_CALL) begin
                        stk_wdata_d = {8'h00, 1'b0, i_pc[22:16]};
                    end else if (op == OP_EXC) begin
                        stk_wdata_d = {i_status_low_byte, 1'b0, i_pc[22:16]};
                    end else begin
                        stk_wdata_d = i_push_data;
                    end
                end
            end
            OP_POP: begin
                // Step down first, then read
                ea = sp_q - WORD_STEP;
                if (stack_bad(ea, lim_q)) begin
                    serr_d = 1'b1;
                end else begin
                    stk_valid_d = 1'b1;
                    stk_addr_d = ea;
                    sp_d = ea;
                end
            end
            OP_LOAD: begin
                // Pointer reloaded by the core, kept word aligned
                sp_d = {i_sp_load[15:1], 1'b0};
            end
            default: begin
                // Idle or unused code: nothing happens
                sp_d = sp_q;
            end
        endcase
    end

    // Stack limit next value; not reset, bit zero forced low
    always_comb begin
        lim_d = lim_q;
        // A new limit is used from the next edge on
        if (i_limit_wr) begin
            lim_d = {i_limit_data[15:1], 1'b0};
        end
    end

    // Data access next state, direct or indirect; faulting access dropped
    always_comb begin
        acc_valid_d = 1'b0;
        acc_write_d = acc_write_q;
        // Address and near flag stand until the next access
        ext_d = ext_q;
        near_d = near_q;
        aerr_d = 1'b0;
        if (i_acc_valid) begin
            if (i_acc_direct) begin
                // Direct reaches only the near region
                ext_d = {8'h00, 3'b000, i_acc_addr[12:0]};
                near_d = 1'b1;
                acc_valid_d = 1'b1;
                acc_write_d = i_acc_write;
            end else if (map_fault) begin
                // Trap instead of the access; nothing reaches memory
                aerr_d = 1'b1;
            end else begin
                // Low or paged mapping from the shared mapper
                ext_d = map_addr;
                near_d = map_near;
                acc_valid_d = 1'b1;
                acc_write_d = i_acc_write;
            end
        end
    end

    // Reset registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            // Requests and traps cleared, pointer at its start
            sp_q <= SP_RESET;
            stk_valid_q <= 1'b0;
            stk_write_q <= 1'b0;
            stk_addr_q <= 16'h0000;
            stk_wdata_q <= 16'h0000;
            acc_valid_q <= 1'b0;
            acc_write_q <= 1'b0;
            ext_q <= 24'h000000;
            near_q <= 1'b0;
            serr_q <= 1'b0;
            aerr_q <= 1'b0;
        end else begin
            // Register next values
            sp_q <= sp_d;
            stk_valid_q <= stk_valid_d;
            stk_write_q <= stk_write_d;
            stk_addr_q <= stk_addr_d;
            stk_wdata_q <= stk_wdata_d;
            acc_valid_q <= acc_valid_d;
            acc_write_q <= acc_write_d;
            ext_q <= ext_d;
            near_q <= near_d;
            serr_q <= serr_d;
            aerr_q <= aerr_d;
        end
    end

    // Limit register deliberately outside reset
    always_ff @(posedge i_sys_clk) begin
        lim_q <= lim_d;
    end

    // Outputs straight from flops
    assign o_stk_valid = stk_valid_q;
    assign o_stk_write = stk_write_q;
    assign o_stk_addr = stk_addr_q;
    assign o_stk_wdata = stk_wdata_q;
    assign o_acc_valid = acc_valid_q;
    assign o_acc_write = acc_write_q;
    assign o_ext_addr = ext_q;
    assign o_acc_near = near_q;
    assign o_stack_pointer_reg = sp_q;
    assign o_stack_limit_reg = lim_q;
    assign o_stack_error_trap = serr_q;
    assign o_address_error_trap = aerr_q;
endmodule

// ==== shared/stack_page_pkg.sv ====
// Package of constants and types for the stack limit and page address checker
// Behaviour
// - Stack pointer addresses next free word, grows up
// - Pop predecrements; push writes then increments
// - Call push zero-extends counter upper byte
// - Exception push joins status low byte, upper byte
// - Stack limit register not reset, undefined
// - Stack limit bit zero always reads zero; here cleared on each write only, undefined before the first
// - Stack pointer addresses compared with stack limit
// - Push at limit ok; next push traps
// - Stack pointer below 0800h raises underflow trap
// - Addresses below 8000h ignore page registers
// - Pages 001h-1FFh select 32K windows upward
// - Page zero at or above 8000h traps
// - Near region reachable directly and indirectly
package stack_page_pkg;
    // Data path widths
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 9;
    localparam int EXT_W = 24;
    // Address thresholds
    localparam logic [15:0] UNDERFLOW_LIMIT = 16'h0800;
    localparam logic [15:0] PAGED_BASE = 16'h8000;
    localparam logic [15:0] NEAR_TOP = 16'h1fff;
    localparam logic [8:0] PAGE_INVALID = 9'h000;
    // Stack pointer reset value, aligned word at the underflow boundary
    localparam logic [15:0] SP_RESET = 16'h0800;
    // Stack word step in bytes
    localparam logic [15:0] WORD_STEP = 16'h0002;
    // Stack operation codes from the core
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_PUSH = 3'b001,
        OP_POP = 3'b010,
        OP_CALL = 3'b011,
        OP_EXC = 3'b100,
        OP_LOAD = 3'b101
    } stack_op_t;
endpackage

// ==== rtl/page_map.sv ====
// Indirect address to extended data space mapping with invalid page detection
`timescale 1ns/100ps
module page_map
    import stack_page_pkg::*;
(
    // Request
    input wire logic [15:0] i_addr,
    input wire logic [8:0] i_page,
    // Result
    output logic [23:0] o_ext_addr,
    output logic o_page_fault,
    output logic o_near
);
    // Combinational mapping, shared by read and write paths
    always_comb begin
        o_near = (i_addr <= NEAR_TOP);
        if (i_addr < PAGED_BASE) begin
            // Page registers ignored, low part of space
            o_ext_addr = {8'h00, i_addr};
            o_page_fault = 1'b0;
        end else begin
            // Page n maps to n*32K + low 15 bits
            o_ext_addr = {i_page, i_addr[14:0]};
            o_page_fault = (i_page == PAGE_INVALID);
        end
    end
endmodule

// ==== verification/stack_page_check_props.sv ====
// Checker for the stack and page checker ports
`timescale 1ns/100ps
module stack_page_check_props
    import stack_page_pkg::*;
(
    // Inputs watched, packed several to a line to stay short
    input wire logic i_sys_clk, i_rst, i_limit_wr, i_acc_valid, i_acc_write, i_acc_direct,
    input wire logic [2:0] i_stack_op,
    input wire logic [22:0] i_pc,
    input wire logic [7:0] i_status_low_byte,
    input wire logic [15:0] i_limit_data, i_acc_addr, o_stk_addr, o_stk_wdata, o_stack_pointer_reg, o_stack_limit_reg,
    input wire logic [8:0] i_data_read_page_reg, i_data_write_page_reg,
    input wire logic o_stk_valid, o_stk_write, o_acc_valid, o_stack_error_trap, o_address_error_trap,
    input wire logic [23:0] o_ext_addr
);
    logic [15:0] ea; // Stack address this op would use
    logic st_ok; // Address inside underflow and limit bounds
    logic [8:0] pg; // Page picked by direction
    logic mem_op; // A stack op that touches memory
    assign ea = (i_stack_op == OP_POP) ? o_stack_pointer_reg - WORD_STEP : o_stack_pointer_reg;
    assign st_ok = ea >= UNDERFLOW_LIMIT && ea <= o_stack_limit_reg;
    assign pg = i_acc_write ? i_data_write_page_reg : i_data_read_page_reg;
    assign mem_op = i_stack_op inside {OP_PUSH, OP_POP, OP_CALL, OP_EXC};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Write at the old pointer, then step up
    sequence s_wr_old; o_stk_valid && o_stk_write && o_stk_addr == $past(o_stack_pointer_reg); endsequence
    sequence s_inc; o_stack_pointer_reg == $past(o_stack_pointer_reg) + WORD_STEP; endsequence
    property p_push; mem_op && i_stack_op != OP_POP && st_ok |=> s_wr_old ##0 s_inc; endproperty
    a_push: assert property (p_push) else $error("push order");
    property p_pop; i_stack_op == OP_POP && st_ok |=> o_stk_valid && !o_stk_write
        && o_stk_addr == o_stack_pointer_reg
        && o_stack_pointer_reg == $past(o_stack_pointer_reg) - WORD_STEP; endproperty
    a_pop: assert property (p_pop) else $error("pop order");
    property p_call; i_stack_op == OP_CALL && st_ok |=> o_stk_wdata == {9'h000, $past(i_pc[22:16])}; endproperty
    a_call: assert property (p_call) else $error("call word");
    property p_exc; i_stack_op == OP_EXC && st_ok
        |=> o_stk_wdata == {$past(i_status_low_byte), 1'b0, $past(i_pc[22:16])}; endproperty
    a_exc: assert property (p_exc) else $error("exception word");
    property p_bad; mem_op && !st_ok
        |=> o_stack_error_trap && !o_stk_valid && $stable(o_stack_pointer_reg); endproperty
    a_bad: assert property (p_bad) else $error("stack trap");
    property p_lim; i_limit_wr |=> o_stack_limit_reg == {$past(i_limit_data[15:1]), 1'b0}; endproperty
    a_lim: assert property (p_lim) else $error("limit bit zero");
    property p_fault; i_acc_valid && !i_acc_direct && i_acc_addr[15] && pg == PAGE_INVALID
        |=> o_address_error_trap && !o_acc_valid; endproperty
    a_fault: assert property (p_fault) else $error("page zero");
    property p_map; i_acc_valid && !i_acc_direct && i_acc_addr[15] && pg != PAGE_INVALID
        |=> o_acc_valid && o_ext_addr == {$past(pg), $past(i_acc_addr[14:0])}; endproperty
    a_map: assert property (p_map) else $error("paged map");
    property p_low; i_acc_valid && !i_acc_direct && !i_acc_addr[15]
        |=> o_ext_addr == {8'h00, $past(i_acc_addr)}; endproperty
    a_low: assert property (p_low) else $error("low map");
endmodule
bind stack_page_check stack_page_check_props chk (.*);

// ==== verification/core_trap_model.sv ====
// Core exception logic model tallying trap requests
`timescale 1ns/100ps
module core_trap_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Trap requests
    input wire logic i_stack_trap,
    input wire logic i_addr_trap,
    // Traps taken
    output int o_trap_count
);
    // Each one-cycle request is one trap, so a stuck level overcounts
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_trap_count <= 0;
        end else begin
            o_trap_count <= o_trap_count + int'(i_stack_trap) + int'(i_addr_trap);
        end
    end
endmodule

// ==== verification/stack_page_check_tb_top.sv ====
// Testbench for the stack and page checker
`timescale 1ns/100ps
module stack_page_check_tb_top;
    import stack_page_pkg::*;
    logic i_sys_clk = 0, i_rst = 1, i_limit_wr = 0, i_acc_valid = 0, i_acc_write = 0, i_acc_direct = 0;
    logic [2:0] i_stack_op = 0;
    logic [15:0] i_push_data = 0, i_sp_load = 0, i_limit_data = 0, i_acc_addr = 0, sp, lim;
    logic [22:0] i_pc = 0;
    logic [7:0] i_status_low_byte = 0;
    logic [8:0] i_data_read_page_reg = 0, i_data_write_page_reg = 0;
    logic o_stk_valid, o_stk_write, o_acc_valid, o_acc_write, o_acc_near, o_stack_error_trap, o_address_error_trap;
    logic [15:0] o_stk_addr, o_stk_wdata, o_stack_pointer_reg, o_stack_limit_reg;
    logic [23:0] o_ext_addr;
    int errors = 0, checks_done = 0, traps = 0, taken;
    stack_page_check dut (.*);
    core_trap_model core (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stack_trap(o_stack_error_trap),
        .i_addr_trap(o_address_error_trap), .o_trap_count(taken));
    initial forever #2.5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Idle edge first, so back-to-back calls never rewrite the op in one time step
    task automatic step(input logic [2:0] o);
        @(posedge i_sys_clk);
        #1 i_stack_op = o;
        @(posedge i_sys_clk);
        #1 i_stack_op = OP_NONE;
    endtask
    task automatic stk(input logic [2:0] o, input logic [15:0] w);
        logic [15:0] a;
        logic ok;
        a = (o == OP_POP) ? sp - WORD_STEP : sp;
        ok = a >= UNDERFLOW_LIMIT && a <= lim;
        step(o);
        chk("stack trap", !ok, o_stack_error_trap);
        chk("stack valid", ok, o_stk_valid);
        if (ok) begin
            chk("stack addr", a, o_stk_addr);
            chk("stack write", o != OP_POP, o_stk_write);
            if (o != OP_POP) chk("stack data", w, o_stk_wdata);
            sp = (o == OP_POP) ? a : sp + WORD_STEP;
        end else traps++;
        chk("pointer", sp, o_stack_pointer_reg);
    endtask
    function automatic logic [23:0] exp_ext(input logic d, input logic [15:0] a, input logic [8:0] p);
        if (d) return {11'h000, a[12:0]};
        return a[15] ? {p, a[14:0]} : {8'h00, a};
    endfunction
    task automatic acc(input logic w, d, input logic [15:0] a, input logic [8:0] p);
        logic bad;
        bad = !d && a[15] && p == PAGE_INVALID;
        @(posedge i_sys_clk);
        #1 {i_acc_write, i_acc_direct, i_acc_addr, i_acc_valid} = {w, d, a, 1'b1};
        i_data_read_page_reg = w ? 9'($urandom) : p;
        i_data_write_page_reg = w ? p : 9'($urandom);
        @(posedge i_sys_clk);
        #1 i_acc_valid = 0;
        chk("addr trap", bad, o_address_error_trap);
        chk("acc valid", !bad, o_acc_valid);
        if (bad) traps++;
        else begin
            chk("ext addr", exp_ext(d, a, p), o_ext_addr);
            chk("acc write", w, o_acc_write);
            chk("near", d || a <= NEAR_TOP, o_acc_near);
        end
    endtask
    task automatic load(input logic [15:0] v);
        i_sp_load = v;
        step(OP_LOAD);
        sp = v;
    endtask
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(27));
        repeat (10) @(posedge i_sys_clk);
        #1 i_rst = 0;
        chk("pointer reset", SP_RESET, o_stack_pointer_reg);
        {i_limit_data, i_limit_wr} = {16'h1001, 1'b1};
        @(posedge i_sys_clk);
        #1 i_limit_wr = 0;
        lim = 16'h1000;
        chk("limit", lim, o_stack_limit_reg);
        @(posedge i_sys_clk);
        #1 load(16'h0ffc);
        for (int i = 0; i < 5; i++) begin
            i_push_data = 16'($urandom);
            stk(OP_PUSH, i_push_data);
        end
        repeat (4) stk(OP_POP, 0);
        load(16'h0802);
        repeat (2) stk(OP_POP, 0);
        for (int i = 0; i < 6; i++) begin
            {i_pc, i_status_low_byte} = 31'($urandom);
            stk(OP_CALL, {9'h000, i_pc[22:16]});
            stk(OP_EXC, {i_status_low_byte, 1'b0, i_pc[22:16]});
        end
        load(16'h0400);
        stk(OP_PUSH, 0);
        acc(0, 0, 16'h8000, 9'h000);
        acc(1, 0, 16'hfffe, 9'h1ff);
        acc(1, 0, 16'h8004, 9'h001);
        acc(0, 1, 16'h1ffe, 9'h000);
        acc(1, 0, 16'h7ffe, 9'h000);
        for (int i = 0; i < 40; i++) acc(1'($urandom), 0, 16'($urandom), 9'($urandom));
        @(posedge i_sys_clk);
        #1 chk("traps taken", 24'(traps), 24'(taken));
        print_verdict();
    end
    initial begin
        #2000;
        errors++;
        print_verdict();
    end
endmodule
